// File: rtl/ths_consts.svh
`ifndef THS_CONSTS_SVH
`define THS_CONSTS_SVH

// Register indices; the byte address is four times the index
`define THS_IDX_MONTH      8'h24
`define THS_IDX_YEAR       8'h25
`define THS_IDX_CTRL       8'h30
`define THS_IDX_STATUS     8'h31
// Byte address width and word offset shift
`define THS_ADDR_W         10
`define THS_WORD_SHIFT     2
// Field positions in the control register
`define THS_CTRL_ENABLE    0
`define THS_CTRL_OVERWRITE 1
`define THS_CTRL_CLEAR     2
// Byte lane that carries the control fields, and the status bit position
`define THS_CTRL_LANE      0
`define THS_STAT_RECORDED  0
// Field widths
`define THS_MONTH_W        5
`define THS_YEAR_W         8
// Reset values
`define THS_MONTH_RST      5'h00
`define THS_YEAR_RST       8'h00
`define THS_CTRL_RST       2'h0
// AXI responses
`define THS_RESP_OKAY      2'h0
`define THS_RESP_SLVERR    2'h2

`endif

// File: rtl/ths_pkg.sv
package ths_pkg;
  typedef logic [31:0] ths_word_t;  // Bus data word
  typedef logic [1:0]  ths_resp_t;  // Bus response code
  // Decoded register select
  typedef enum { THS_SEL_MONTH, THS_SEL_YEAR, THS_SEL_CTRL,
                 THS_SEL_STATUS, THS_SEL_NONE } ths_sel_e;
endpackage

// File: rtl/ths_capture.sv
`timescale 1ns/10ps
`include "ths_consts.svh"

// Holds the month and year stamp of a high temperature event
module ths_capture
  import ths_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_event,     // One-cycle high event
  input  wire logic                      i_enable,    // Capture enable
  input  wire logic                      i_overwrite, // 1 keeps last, 0 keeps first
  input  wire logic                      i_clear,     // One-cycle clear pulse
  input  wire logic [`THS_MONTH_W-1:0]   i_month,     // Live calendar month, BCD
  input  wire logic [`THS_YEAR_W-1:0]    i_year,      // Live calendar year, BCD
  output logic      [`THS_MONTH_W-1:0]   o_month,
  output logic      [`THS_YEAR_W-1:0]    o_year,
  output logic                           o_recorded
);
  logic [`THS_MONTH_W-1:0] month_reg, month_next;  // Stored month
  logic [`THS_YEAR_W-1:0]  year_reg,  year_next;   // Stored year
  logic                    rec_reg,   rec_next;    // A stamp is held
  logic                    take;                   // Capture this cycle

  // Next stamp; an enabled event in the clear cycle wins, unless keep-first mode already holds a stamp
  always_comb begin
    take       = i_event && i_enable && (i_overwrite || !rec_reg);
    month_next = month_reg;
    year_next  = year_reg;
    rec_next   = rec_reg;
    if (take) begin
      month_next = i_month;
      year_next  = i_year;
      rec_next   = 1'b1;
    end else if (i_clear) begin
      month_next = `THS_MONTH_RST;
      year_next  = `THS_YEAR_RST;
      rec_next   = 1'b0;
    end
  end

  // Stamp storage, zero after power-on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      month_reg <= `THS_MONTH_RST;
      year_reg  <= `THS_YEAR_RST;
      rec_reg   <= 1'b0;
    end else begin
      month_reg <= month_next;
      year_reg  <= year_next;
      rec_reg   <= rec_next;
    end
  end

  assign o_month    = month_reg;
  assign o_year     = year_reg;
  assign o_recorded = rec_reg;
endmodule // ths_capture

// File: rtl/ths_stamp_regs.sv
// Function
// - Month stamp held as BCD 01 to 12
// - Month in bits 4:0, tens in bit 4
// - Month bits 7:5 read zero, unwritable
// - Enable gates capture; select keeps first/last
// - Clear write forces month stamp to 00h; an event captured in the clear cycle is stored instead
// - Reads 00 until a stamp is recorded
// - Year stamp held as BCD 00 to 99
// - Software writes to stamp registers never change them
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "ths_consts.svh"

module ths_stamp_regs
  import ths_pkg::*;
(
  input  wire logic                     I_CLOCK,
  input  wire logic                     I_RST_N,
  // Event source and live calendar, same clock domain
  input  wire logic                     I_HIGH_EVENT,
  input  wire logic [`THS_MONTH_W-1:0]  I_CUR_MONTH,
  input  wire logic [`THS_YEAR_W-1:0]   I_CUR_YEAR,
  // AXI4-Lite write address
  input  wire logic [`THS_ADDR_W-1:0]   I_AWADDR,
  input  wire logic [2:0]               I_AWPROT,
  input  wire logic                     I_AWVALID,
  output logic                          O_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0]              I_WDATA,
  input  wire logic [3:0]               I_WSTRB,
  input  wire logic                     I_WVALID,
  output logic                          O_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                    O_BRESP,
  output logic                          O_BVALID,
  input  wire logic                     I_BREADY,
  // AXI4-Lite read address
  input  wire logic [`THS_ADDR_W-1:0]   I_ARADDR,
  input  wire logic [2:0]               I_ARPROT,
  input  wire logic                     I_ARVALID,
  output logic                          O_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]                   O_RDATA,
  output logic [1:0]                    O_RRESP,
  output logic                          O_RVALID,
  input  wire logic                     I_RREADY
);

  // Map a byte address to a register; low two bits are ignored
  function automatic ths_sel_e decode(input logic [`THS_ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[`THS_ADDR_W-1:`THS_WORD_SHIFT];
    if (idx == `THS_IDX_MONTH)       decode = THS_SEL_MONTH;
    else if (idx == `THS_IDX_YEAR)   decode = THS_SEL_YEAR;
    else if (idx == `THS_IDX_CTRL)   decode = THS_SEL_CTRL;
    else if (idx == `THS_IDX_STATUS) decode = THS_SEL_STATUS;
    else                             decode = THS_SEL_NONE;
  endfunction

  // Write channel state
  logic [`THS_ADDR_W-1:0] awaddr_reg, awaddr_next;   // Held write address
  logic                   aw_held_reg, aw_held_next; // Address taken
  logic [31:0]            wdata_reg,  wdata_next;    // Held write data
  logic [3:0]             wstrb_reg,  wstrb_next;    // Held strobes
  logic                   w_held_reg, w_held_next;   // Data taken
  logic                   awready_reg, awready_next;
  logic                   wready_reg,  wready_next;
  logic                   bvalid_reg,  bvalid_next;
  logic [1:0]             bresp_reg,   bresp_next;
  // Control state
  logic                   en_reg,  en_next;          // Capture enable
  logic                   ovw_reg, ovw_next;         // high_stamp_overwrite_select
  logic                   clr_reg, clr_next;         // high_stamp_clear pulse
  // Read channel state
  logic                   arready_reg, arready_next;
  logic                   rvalid_reg,  rvalid_next;
  logic [31:0]            rdata_reg,   rdata_next;
  logic [1:0]             rresp_reg,   rresp_next;
  // Stamp contents
  logic [`THS_MONTH_W-1:0] stamp_month;
  logic [`THS_YEAR_W-1:0]  stamp_year;
  logic                    stamp_rec;
  ths_sel_e                wsel;                     // Decoded write target
  ths_sel_e                rsel;                     // Decoded read target

  // Stamp storage and capture policy
  ths_capture i_ths_capture (
    .i_clk       (I_CLOCK),
    .i_rst_n     (I_RST_N),
    .i_event     (I_HIGH_EVENT),
    .i_enable    (en_reg),
    .i_overwrite (ovw_reg),
    .i_clear     (clr_reg),
    .i_month     (I_CUR_MONTH),
    .i_year      (I_CUR_YEAR),
    .o_month     (stamp_month),
    .o_year      (stamp_year),
    .o_recorded  (stamp_rec)
  );

  // Write path: take address and data in any order, then answer
  always_comb begin
    awaddr_next  = awaddr_reg;
    aw_held_next = aw_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    w_held_next  = w_held_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    en_next      = en_reg;
    ovw_next     = ovw_reg;
    clr_next     = 1'b0;  // Clear is a single-cycle pulse
    wsel         = decode(awaddr_reg);
    if (I_AWVALID && awready_reg) begin
      awaddr_next  = I_AWADDR;
      aw_held_next = 1'b1;
    end
    if (I_WVALID && wready_reg) begin
      wdata_next  = I_WDATA;
      wstrb_next  = I_WSTRB;
      w_held_next = 1'b1;
    end
    if (bvalid_reg && I_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `THS_RESP_OKAY;
      unique case (wsel)
        THS_SEL_MONTH, THS_SEL_YEAR, THS_SEL_STATUS: begin
          // Stamps are read-only; write accepted and dropped
          bresp_next = `THS_RESP_OKAY;
        end
        THS_SEL_CTRL: begin
          if (wstrb_reg[`THS_CTRL_LANE]) begin
            en_next  = wdata_reg[`THS_CTRL_ENABLE];
            ovw_next = wdata_reg[`THS_CTRL_OVERWRITE];
            clr_next = wdata_reg[`THS_CTRL_CLEAR];
          end
        end
        THS_SEL_NONE: begin
          bresp_next = `THS_RESP_SLVERR;  // Unmapped address
        end
      endcase
    end
    // One write in flight; ready drops while a channel is held
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
  end

  // Write path registers
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      awaddr_reg  <= '0;
      aw_held_reg <= 1'b0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      w_held_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `THS_RESP_OKAY;
      en_reg      <= 1'b0;
      ovw_reg     <= 1'b0;
      clr_reg     <= 1'b0;
    end else begin
      awaddr_reg  <= awaddr_next;
      aw_held_reg <= aw_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      w_held_reg  <= w_held_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      en_reg      <= en_next;
      ovw_reg     <= ovw_next;
      clr_reg     <= clr_next;
    end
  end

  // Read path: data registered one cycle after the address is taken
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    rsel        = decode(I_ARADDR);
    if (rvalid_reg && I_RREADY) begin
      rvalid_next = 1'b0;
    end
    if (I_ARVALID && arready_reg) begin
      rvalid_next = 1'b1;
      rdata_next  = '0;  // Unused and reserved bits read zero
      rresp_next  = `THS_RESP_OKAY;
      unique case (rsel)
        THS_SEL_MONTH:  rdata_next[`THS_MONTH_W-1:0] = stamp_month;
        THS_SEL_YEAR:   rdata_next[`THS_YEAR_W-1:0]  = stamp_year;
        THS_SEL_CTRL: begin
          rdata_next[`THS_CTRL_ENABLE]    = en_reg;
          rdata_next[`THS_CTRL_OVERWRITE] = ovw_reg;
        end
        THS_SEL_STATUS: rdata_next[`THS_STAT_RECORDED] = stamp_rec;
        THS_SEL_NONE:   rresp_next    = `THS_RESP_SLVERR;
      endcase
    end
    arready_next = !rvalid_next;
  end

  // Read path registers
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `THS_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign O_AWREADY = awready_reg;
  assign O_WREADY  = wready_reg;
  assign O_BVALID  = bvalid_reg;
  assign O_BRESP   = bresp_reg;
  assign O_ARREADY = arready_reg;
  assign O_RVALID  = rvalid_reg;
  assign O_RDATA   = rdata_reg;
  assign O_RRESP   = rresp_reg;
endmodule // ths_stamp_regs

// File: verification/ths_stamp_regs_asserts.sv
`timescale 1ns/10ps
`include "ths_consts.svh"

// Read-side format and bus handshake checks
module ths_stamp_regs_chk
  import ths_pkg::*;
(
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  input  wire logic [9:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  input  wire logic        O_ARREADY,
  input  wire logic [31:0] O_RDATA,
  input  wire logic [1:0]  O_RRESP,
  input  wire logic        O_RVALID,
  input  wire logic        I_RREADY,
  input  wire logic        O_AWREADY,
  input  wire logic        O_WREADY,
  input  wire logic [1:0]  O_BRESP,
  input  wire logic        O_BVALID,
  input  wire logic        I_BREADY
);
  logic [7:0] idx_reg;   // Index of the read in flight
  logic [7:0] idx_next;
  // Remember which register the pending read names
  always_comb begin
    idx_next = idx_reg;
    if (I_ARVALID && O_ARREADY) begin
      idx_next = I_ARADDR[9:2];
    end
  end
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      idx_reg <= 8'h00;
    end else begin
      idx_reg <= idx_next;
    end
  end
  wire logic rd_mon = O_RVALID && (idx_reg == `THS_IDX_MONTH);
  wire logic rd_yr  = O_RVALID && (idx_reg == `THS_IDX_YEAR);
  wire logic rd_map = rd_mon || rd_yr || idx_reg == `THS_IDX_CTRL || idx_reg == `THS_IDX_STATUS;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  AST_MONTH_TOP_ZERO: assert property (rd_mon |-> O_RDATA[31:5] == 27'h000_0000)
    else $error("month upper bits not zero");
  AST_MONTH_BCD: assert property (rd_mon && O_RDATA[4:0] != 5'h00 |-> O_RDATA[3:0] <= 4'h9
    && (!O_RDATA[4] || O_RDATA[3:0] <= 4'h2)) else $error("month not BCD 01 to 12");
  AST_YEAR_BCD: assert property (rd_yr |-> O_RDATA[31:8] == 24'h00_0000
    && O_RDATA[7:4] <= 4'h9 && O_RDATA[3:0] <= 4'h9) else $error("year not BCD");
  AST_UNMAPPED_READ: assert property (O_RVALID && !rd_map |-> O_RRESP == `THS_RESP_SLVERR
    && O_RDATA == 32'h0000_0000) else $error("unmapped read not refused");
  AST_R_ANSWER: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  AST_R_STANDS: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  AST_B_STANDS: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  AST_W_BLOCKED: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while response pending");
  AST_AR_BLOCKED: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read taken while data pending");
  cover property (rd_mon && O_RDATA[4:0] != 5'h00);
  cover property (O_BVALID && I_BREADY);
  cover property (O_RVALID && O_RRESP == `THS_RESP_SLVERR);
endmodule // ths_stamp_regs_chk

bind ths_stamp_regs ths_stamp_regs_chk i_ths_stamp_regs_chk (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_AWREADY(O_AWREADY), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
  .O_BVALID(O_BVALID), .I_BREADY(I_BREADY));

// File: verification/tb_top.sv
`timescale 1ns/10ps
`include "ths_consts.svh"

module tb_top
  import ths_pkg::*;
();
  logic I_CLOCK, I_RST_N, I_HIGH_EVENT, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [4:0] I_CUR_MONTH;
  logic [7:0] I_CUR_YEAR;
  logic [9:0] I_AWADDR, I_ARADDR;
  ths_word_t  I_WDATA, O_RDATA;
  ths_resp_t  O_BRESP, O_RRESP;
  int         n_mismatch, n_compared;
  // Byte addresses are four times the register index
  localparam logic [9:0] AMON = 10'(`THS_IDX_MONTH) << `THS_WORD_SHIFT;
  localparam logic [9:0] AYR  = 10'(`THS_IDX_YEAR) << `THS_WORD_SHIFT;
  localparam logic [9:0] ACTL = 10'(`THS_IDX_CTRL) << `THS_WORD_SHIFT;
  localparam logic [9:0] AST  = 10'(`THS_IDX_STATUS) << `THS_WORD_SHIFT;
  localparam ths_resp_t OK = `THS_RESP_OKAY;
  ths_stamp_regs i_ths_stamp_regs (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
    .I_HIGH_EVENT(I_HIGH_EVENT), .I_CUR_MONTH(I_CUR_MONTH), .I_CUR_YEAR(I_CUR_YEAR),
    .I_AWADDR(I_AWADDR), .I_AWPROT(3'h0), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WDATA(I_WDATA), .I_WSTRB(4'hf), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY),
    .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR),
    .I_ARPROT(3'h0), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY));
  // Free-running bench clock
  initial begin
    I_CLOCK = 1'b0;
    forever #5 I_CLOCK = ~I_CLOCK;
  end
  task automatic check(input string what, input ths_word_t exp, input ths_word_t got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  // One write; each channel dropped once taken, only the watchdog ends a hang
  task automatic wr(input logic [9:0] a, input ths_word_t d, input ths_resp_t er);
    @(posedge I_CLOCK);
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    do begin
      @(posedge I_CLOCK);
      if (O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
      if (O_WREADY === 1'b1) I_WVALID <= 1'b0;
    end while (O_BVALID !== 1'b1);
    I_BREADY <= 1'b0;
    check("bresp", 32'(er), 32'(O_BRESP));
  endtask
  // One read, judged against the expected word and response
  task automatic rd(input logic [9:0] a, input ths_word_t ed, input ths_resp_t er);
    @(posedge I_CLOCK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do begin
      @(posedge I_CLOCK);
      if (O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
    end while (O_RVALID !== 1'b1);
    I_RREADY <= 1'b0;
    check("rdata", ed, O_RDATA);
    check("rresp", 32'(er), 32'(O_RRESP));
  endtask
  // One-cycle high event with the live calendar value
  task automatic stamp(input logic [4:0] m, input logic [7:0] y);
    @(posedge I_CLOCK);
    I_CUR_MONTH <= m;
    I_CUR_YEAR <= y;
    I_HIGH_EVENT <= 1'b1;
    @(posedge I_CLOCK);
    I_HIGH_EVENT <= 1'b0;
  endtask
  task automatic t_reset();
    rd(AMON, 32'h0000_0000, OK);
    rd(AYR, 32'h0000_0000, OK);
  endtask
  task automatic t_first_last();
    wr(ACTL, 32'h0000_0001, OK);
    stamp(5'h12, 8'h99);
    stamp(5'h01, 8'h00);
    rd(AMON, 32'h0000_0012, OK);
    rd(AYR, 32'h0000_0099, OK);
    wr(ACTL, 32'h0000_0003, OK);
    rd(ACTL, 32'h0000_0003, OK);
    stamp(5'h09, 8'h42);
    rd(AMON, 32'h0000_0009, OK);
    wr(ACTL, 32'h0000_0002, OK);
    stamp(5'h11, 8'h55);
    rd(AYR, 32'h0000_0042, OK);
  endtask
  task automatic t_ro_write();
    wr(AMON, 32'hffff_ffff, OK);
    wr(AYR, 32'hffff_ffff, OK);
    rd(AMON, 32'h0000_0009, OK);
    rd(AYR, 32'h0000_0042, OK);
  endtask
  task automatic t_clear();
    wr(ACTL, 32'h0000_0004, OK);
    rd(ACTL, 32'h0000_0000, OK);
    rd(AMON, 32'h0000_0000, OK);
    rd(AYR, 32'h0000_0000, OK);
    rd(AST, 32'h0000_0000, OK);
    wr(ACTL, 32'h0000_0001, OK);
    stamp(5'h10, 8'h00);
    rd(AMON, 32'h0000_0010, OK);
    rd(AST, 32'h0000_0001, OK);
  endtask
  // Reset in mid-run, with a stamp held, must bring the stamps back to zero
  task automatic t_mid_reset();
    @(posedge I_CLOCK);
    I_RST_N <= 1'b0;
    repeat (2) @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    rd(AMON, 32'h0000_0000, OK);
    rd(AST, 32'h0000_0000, OK);
  endtask
  task automatic t_unmapped();
    rd(10'h000, 32'h0000_0000, `THS_RESP_SLVERR);
    wr(10'h3fc, 32'h0000_0001, `THS_RESP_SLVERR);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles the tests need
  initial begin
    #100us;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {I_RST_N, I_HIGH_EVENT, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 7'h00;
    {I_CUR_MONTH, I_CUR_YEAR, I_AWADDR, I_ARADDR, I_WDATA} = '0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (4) @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    t_reset();
    t_first_last();
    t_ro_write();
    t_clear();
    t_mid_reset();
    t_unmapped();
    report_and_stop();
  end
endmodule // tb_top
